// [die_id_pkg.sv]
/*
  Package for the die identifier bank: location word indices, field positions and bus constants.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package die_id_pkg;

  localparam int unsigned ID_BITS   = 96;
  localparam int unsigned ID_BYTES  = 12;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned IDX_W     = 4;

  // The location offsets are not all multiples of four, so each is a word index and the byte address is four times it.
  localparam logic [ADDR_W-1:0] DIE_X_COORD_LOW_IDX  = 16'h4926;
  localparam logic [ADDR_W-1:0] DIE_X_COORD_HIGH_IDX = 16'h4927;
  localparam logic [ADDR_W-1:0] DIE_Y_COORD_LOW_IDX  = 16'h4928;
  localparam logic [ADDR_W-1:0] DIE_Y_COORD_HIGH_IDX = 16'h4929;
  localparam logic [ADDR_W-1:0] WAFER_NUMBER_IDX     = 16'h492a;
  localparam logic [ADDR_W-1:0] LOT_NUMBER_BYTE0_IDX = 16'h492b;
  localparam logic [ADDR_W-1:0] LOT_NUMBER_BYTE1_IDX = 16'h492c;
  localparam logic [ADDR_W-1:0] LOT_NUMBER_BYTE2_IDX = 16'h492d;
  localparam logic [ADDR_W-1:0] LOT_NUMBER_BYTE3_IDX = 16'h492e;
  localparam logic [ADDR_W-1:0] LOT_NUMBER_BYTE4_IDX = 16'h492f;
  localparam logic [ADDR_W-1:0] LOT_NUMBER_BYTE5_IDX = 16'h4930;
  localparam logic [ADDR_W-1:0] LOT_NUMBER_BYTE6_IDX = 16'h4931;

  // Field positions inside the identifier.
  localparam int unsigned X_COORD_LSB = 0;
  localparam int unsigned Y_COORD_LSB = 16;
  localparam int unsigned WAFER_LSB   = 32;
  localparam int unsigned LOT_LSB     = 40;
  localparam int unsigned LOT_BYTES   = 7;

  // Reset value of the read data output.
  localparam logic [DATA_W-1:0] PRDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

  // Returns the byte slot for an index, or ID_BYTES when the index is outside the bank.
  function automatic logic [IDX_W:0] slot_of(input logic [ADDR_W-1:0] idx);
    logic [ADDR_W-1:0] rel;
    rel = idx - DIE_X_COORD_LOW_IDX;
    if (idx < DIE_X_COORD_LOW_IDX || idx > LOT_NUMBER_BYTE6_IDX) begin
      return 5'(ID_BYTES);
    end else begin
      return rel[IDX_W:0];
    end
  endfunction

endpackage

// [id_rd_if.sv]
/*
  Read port between the bus slave and the identifier store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface id_rd_if;
  import die_id_pkg::*;
  logic             rd_en;
  logic [IDX_W-1:0] rd_slot;
  logic [7:0]       rd_byte;

  modport requester (output rd_en, output rd_slot, input rd_byte);
  modport store     (input rd_en, input rd_slot, output rd_byte);
endinterface

// [die_id_store.sv]
/*
  Fixed store of the twelve identifier bytes; the read byte comes out of a register.
  Assumes the requester gives a slot below twelve whenever it strobes a read.
*/
`timescale 1ns/1ps
module die_id_store
#(
  parameter logic [95:0] ID_VALUE = 96'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  id_rd_if.store   rd
);
  import die_id_pkg::*;

  logic [7:0] byte_reg;

  // The content is a constant; there is no write path at all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_reg <= 8'h00;
    end else if (rd.rd_en) begin
      byte_reg <= ID_VALUE[{rd.rd_slot, 3'b000} +: 8];
    end
  end

  assign rd.rd_byte = byte_reg;

endmodule

// [die_identifier_rom.sv]
/*
  APB slave that returns a fixed 96-bit die identifier, one byte per word location.
  Assumes an APB master with 32-bit data; the identifier is fixed at build time by a parameter.
*/
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module die_identifier_rom
#(
  // Per-die value; the default is arbitrary and is replaced when the die is personalised.
  parameter logic [95:0] ID_VALUE = 96'h5a3c_0f96_e187_2d4b_a5c3_1e78
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [die_id_pkg::ADDR_W+1:0] paddr,
  input  wire logic [die_id_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic                              pready,
  output logic [die_id_pkg::DATA_W-1:0]     prdata,
  output logic                              pslverr
);
  import die_id_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode.

  id_rd_if rd_if ();

  bus_state_t        state_reg;
  bus_state_t        state_next;
  logic [ADDR_W-1:0] word_idx;
  logic [IDX_W:0]    slot;
  logic              setup;
  logic              hit;
  logic              write_reg;
  logic              hit_reg;

  // Unaligned low address bits are ignored; the word index selects the location.
  assign word_idx = paddr[ADDR_W+1:2];
  assign hit      = (slot != 5'(ID_BYTES));
  assign setup    = psel && !penable;

  // Each location maps to one byte slot of the identifier; slot ID_BYTES means no location.
  always_comb begin
    slot = 5'(ID_BYTES);
    if (word_idx == DIE_X_COORD_LOW_IDX) begin
      slot = 5'(X_COORD_LSB / 8);
    end else if (word_idx == DIE_X_COORD_HIGH_IDX) begin
      slot = 5'(X_COORD_LSB / 8 + 1);
    end else if (word_idx == DIE_Y_COORD_LOW_IDX) begin
      slot = 5'(Y_COORD_LSB / 8);
    end else if (word_idx == DIE_Y_COORD_HIGH_IDX) begin
      slot = 5'(Y_COORD_LSB / 8 + 1);
    end else if (word_idx == WAFER_NUMBER_IDX) begin
      slot = 5'(WAFER_LSB / 8);
    end else if (word_idx == LOT_NUMBER_BYTE0_IDX) begin
      slot = 5'(LOT_LSB / 8);
    end else if (word_idx == LOT_NUMBER_BYTE1_IDX) begin
      slot = 5'(LOT_LSB / 8 + 1);
    end else if (word_idx == LOT_NUMBER_BYTE2_IDX) begin
      slot = 5'(LOT_LSB / 8 + 2);
    end else if (word_idx == LOT_NUMBER_BYTE3_IDX) begin
      slot = 5'(LOT_LSB / 8 + 3);
    end else if (word_idx == LOT_NUMBER_BYTE4_IDX) begin
      slot = 5'(LOT_LSB / 8 + 4);
    end else if (word_idx == LOT_NUMBER_BYTE5_IDX) begin
      slot = 5'(LOT_LSB / 8 + 5);
    end else if (word_idx == LOT_NUMBER_BYTE6_IDX) begin
      slot = 5'(LOT_LSB / 8 + LOT_BYTES - 1);
    end
  end

  assign rd_if.rd_en   = setup && hit && !pwrite;
  assign rd_if.rd_slot = slot[IDX_W-1:0];

  die_id_store #(
    .ID_VALUE (ID_VALUE)
  ) u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .rd      (rd_if)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus sequencing: every access answers in its first access-phase cycle.

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BUS_IDLE: begin
        if (setup) begin
          state_next = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_reg <= 1'b0;
      hit_reg   <= 1'b0;
    end else if (setup) begin
      write_reg <= pwrite;
      hit_reg   <= hit;
    end
  end

  // Ready is registered so that it comes straight from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Writes are accepted and dropped, so the bank never raises an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data: the byte sits in bits 7:0 and the upper bits read as zero.

  logic rd_pending_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pending_reg <= 1'b0;
    end else begin
      rd_pending_reg <= rd_if.rd_en;
    end
  end

  // The bus data register loads the byte at the setup edge, in step with the store's own
  // register, so prdata stays a flip-flop output; it is cleared in every other cycle.
  logic [DATA_W-1:0] prdata_next;

  always_comb begin
    prdata_next = PRDATA_RESET;
    if (setup && hit && !pwrite) begin
      prdata_next = {24'h000000, ID_VALUE[{slot[IDX_W-1:0], 3'b000} +: 8]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PRDATA_RESET;
    end else begin
      prdata <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_read_setup;
    psel && !penable && !pwrite && hit;
  endsequence

  chk_ready_follows_setup: assert property (
    @(posedge pclk) disable iff (!presetn) (psel && !penable) |=> pready)
    else $error("pready did not follow a setup cycle");

  chk_no_error_ever: assert property (
    @(posedge pclk) disable iff (!presetn) pready |-> !pslverr)
    else $error("slave error raised");

  chk_x_low_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and paddr[ADDR_W+1:2] == DIE_X_COORD_LOW_IDX) |=> prdata == {24'h0, ID_VALUE[7:0]})
    else $error("x low byte wrong");

  chk_y_high_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and paddr[ADDR_W+1:2] == DIE_Y_COORD_HIGH_IDX) |=> prdata == {24'h0, ID_VALUE[31:24]})
    else $error("y high byte wrong");

  chk_wafer_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and paddr[ADDR_W+1:2] == WAFER_NUMBER_IDX) |=> prdata == {24'h0, ID_VALUE[39:32]})
    else $error("wafer byte wrong");

  chk_lot_top_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and paddr[ADDR_W+1:2] == LOT_NUMBER_BYTE6_IDX) |=> prdata == {24'h0, ID_VALUE[95:88]})
    else $error("lot top byte wrong");

  chk_store_matches: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_pending_reg |-> rd_if.rd_byte == prdata[7:0])
    else $error("store byte differs from bus data");

  chk_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn) prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");

  chk_write_no_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && pwrite) |=> (pready && prdata == PRDATA_RESET))
    else $error("write returned data");

  // One check per remaining location; each compares with the parameter slice itself,
  // so a slip in the location decode cannot hide behind the same arithmetic.
  chk_x_high_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == DIE_X_COORD_HIGH_IDX) |=> prdata == {24'h0, ID_VALUE[15:8]})
    else $error("x high byte wrong");

  chk_y_low_byte: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == DIE_Y_COORD_LOW_IDX) |=> prdata == {24'h0, ID_VALUE[23:16]})
    else $error("y low byte wrong");

  chk_lot_byte_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == LOT_NUMBER_BYTE0_IDX) |=> prdata == {24'h0, ID_VALUE[47:40]})
    else $error("lot byte 0 wrong");

  chk_lot_byte_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == LOT_NUMBER_BYTE1_IDX) |=> prdata == {24'h0, ID_VALUE[55:48]})
    else $error("lot byte 1 wrong");

  chk_lot_byte_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == LOT_NUMBER_BYTE2_IDX) |=> prdata == {24'h0, ID_VALUE[63:56]})
    else $error("lot byte 2 wrong");

  chk_lot_byte_three: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == LOT_NUMBER_BYTE3_IDX) |=> prdata == {24'h0, ID_VALUE[71:64]})
    else $error("lot byte 3 wrong");

  chk_lot_byte_four: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == LOT_NUMBER_BYTE4_IDX) |=> prdata == {24'h0, ID_VALUE[79:72]})
    else $error("lot byte 4 wrong");

  chk_lot_byte_five: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_read_setup and word_idx == LOT_NUMBER_BYTE5_IDX) |=> prdata == {24'h0, ID_VALUE[87:80]})
    else $error("lot byte 5 wrong");

  // Protocol, decode and side-effect checks, in the answer cycle and outside it.
  chk_ready_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn) pready |=> !pready)
    else $error("pready stood for more than one cycle");

  chk_state_tracks: assert property (
    @(posedge pclk) disable iff (!presetn) pready == (state_reg == BUS_ANSWER))
    else $error("bus state and pready disagree");

  chk_unmapped_zero: assert property (
    @(posedge pclk) disable iff (!presetn) (pready && !hit_reg) |-> prdata == PRDATA_RESET)
    else $error("unmapped location returned data");

  chk_write_flagged: assert property (
    @(posedge pclk) disable iff (!presetn) (pready && write_reg) |-> (prdata == PRDATA_RESET && !pslverr))
    else $error("write answer carried data or error");

  chk_idle_data_zero: assert property (
    @(posedge pclk) disable iff (!presetn) !pready |-> prdata == PRDATA_RESET)
    else $error("read data outside an answer");

  chk_decode_agrees: assert property (
    @(posedge pclk) disable iff (!presetn) setup |-> slot == slot_of(word_idx))
    else $error("location decode disagrees with range decode");

  chk_store_holds: assert property (
    @(posedge pclk) disable iff (!presetn) !rd_if.rd_en |=> $stable(rd_if.rd_byte))
    else $error("store byte changed without a read");

endmodule

// [die_identifier_rom_test.sv]
/*
  Self-checking bench for the die identifier bank, driven as an APB master.
  Assumes the slave answers each transfer with pready and that all identifier bytes are fixed.
*/
`timescale 1ns/1ps
module die_identifier_rom_test;
  import die_id_pkg::*;

  // Identifier under test; the value is arbitrary and every byte differs.
  localparam logic [95:0] ID = 96'h0123_4567_89ab_cdef_fedc_ba98;

  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W+1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [3:0]          pstrb;
  logic                pready;
  logic [DATA_W-1:0]   prdata;
  logic                pslverr;
  logic [DATA_W-1:0]   rd;
  logic                err;
  int                  fail_count;
  int                  num_checks;

  die_identifier_rom #(.ID_VALUE(ID)) u_die_identifier_rom (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr)
  );

  always #20 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Leaves psel and penable up so that a following call starts its setup cycle at once.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= w ? 4'hf : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end else begin
      rd  = prdata;
      err = pslverr;
    end
  endtask

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    check({31'h0, pready}, 32'h0);
    check(prdata, 32'h0);
  endtask

  // Back-to-back reads of all twelve bytes, each compared with its slice of the identifier.
  task automatic read_all();
    for (int k = 0; k < ID_BYTES; k++) begin
      xfer(1'b0, ADDR_W'(DIE_X_COORD_LOW_IDX + k), 32'h0);
      check(rd, {24'h0, ID[8*k +: 8]});
      check({31'h0, err}, 32'h0);
    end
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (8) @(posedge pclk);
    check({30'h0, pready, pslverr}, 32'h0);
    check(prdata, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    read_all();
    // Writes of inverted patterns everywhere must leave no trace.
    for (int k = 0; k < ID_BYTES; k++) begin
      xfer(1'b1, ADDR_W'(DIE_X_COORD_LOW_IDX + k), ~{24'h0, ID[8*k +: 8]});
      check({31'h0, err}, 32'h0);
      check(rd, 32'h0);
    end
    idle();
    read_all();
    // Locations just outside the bank read as zero without an error.
    xfer(1'b0, ADDR_W'(DIE_X_COORD_LOW_IDX - 1), 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h0);
    xfer(1'b0, ADDR_W'(LOT_NUMBER_BYTE6_IDX + 1), 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h0);
    idle();
    // A second reset must not disturb the fixed contents.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({30'h0, pready, pslverr}, 32'h0);
    check(prdata, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    read_all();
    summarize();
  end
endmodule
